// >>> hw/odl_loader.sv
`timescale 1ns/10ps
`include "odl_regs.svh"
module odl_loader #(
  parameter int unsigned P_SETTLE_CYC = `ODL_SETTLE_CYC
) (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Serial link
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_load_strobe,
  output logic o_serial_out,
  // Channel codes to the converters
  output odl_pkg::odl_val_t [`ODL_CHAN_N-1:0] o_analog_channel_outputs,
  output logic [`ODL_CHAN_N-1:0] o_channel_settled
);
  import odl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] f_addr(input logic [3:0] field);
    f_addr = {field[0], field[1], field[2], field[3]};
  endfunction

  function automatic odl_sel_t f_decode(input logic [3:0] field);
    logic [3:0] a;
    odl_sel_t s;
    a = f_addr(field);
    s = '0;
    if (a >= `ODL_ADDR_FIRST && a <= `ODL_ADDR_LAST) begin
      s[3'(a - `ODL_ADDR_FIRST)] = 1'b1;
    end
    f_decode = s;
  endfunction

  function automatic logic [63:0] f_expand(input odl_sel_t sel);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < `ODL_CHAN_N; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    f_expand = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain

  logic [1:0] lrst_sync_ff;
  logic [`ODL_WORD_W-1:0] shift_ff;
  logic lrst;

  always_ff @(posedge i_shift_clk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], i_srst};
  end

  assign lrst = lrst_sync_ff[1];

  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      shift_ff <= `ODL_SHIFT_RST;
    end else begin
      shift_ff <= {shift_ff[`ODL_WORD_W-2:0], i_serial_in};
    end
  end

  assign o_serial_out = shift_ff[`ODL_WORD_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Load strobe crossing

  logic strobe_meta_ff;
  logic strobe_sync_ff;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strobe_meta_ff <= 1'b0;
      strobe_sync_ff <= 1'b0;
    end else begin
      strobe_meta_ff <= i_load_strobe;
      strobe_sync_ff <= strobe_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  odl_load_e st_ff;
  odl_load_e nxt_st;
  odl_word_s word_ff;
  odl_sel_t wr_sel;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (strobe_sync_ff) begin
          nxt_st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        nxt_st = ST_HOLD;
      end
      ST_HOLD: begin
        if (!strobe_sync_ff) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Word is static while the strobe is high, so it is taken once the
  // synchronised strobe is seen
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      word_ff <= '0;
    end else if (st_ff == ST_IDLE && strobe_sync_ff) begin
      word_ff <= shift_ff;
    end
  end

  assign wr_sel = (st_ff == ST_WRITE) ? f_decode(word_ff.channel_address_field) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Channel latches

  odl_val_t [`ODL_CHAN_N-1:0] chan_ff;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chan_ff <= {`ODL_CHAN_N{`ODL_VAL_RST}};
    end else begin
      for (int i = 0; i < `ODL_CHAN_N; i++) begin
        if (wr_sel[i]) begin
          chan_ff[i] <= word_ff.conversion_value_field;
        end
      end
    end
  end

  assign o_analog_channel_outputs = chan_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Settling timers

  logic [`ODL_CNT_W-1:0] settle_ff [`ODL_CHAN_N];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < `ODL_CHAN_N; i++) begin
        settle_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `ODL_CHAN_N; i++) begin
        if (wr_sel[i]) begin
          settle_ff[i] <= `ODL_CNT_W'(P_SETTLE_CYC);
        end else if (settle_ff[i] != '0) begin
          settle_ff[i] <= settle_ff[i] - 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settled flags

  logic [`ODL_CHAN_N-1:0] settled_ff;

  // Flag drops with a write and returns as the timer reaches zero; a write wins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      settled_ff <= '1;
    end else begin
      for (int i = 0; i < `ODL_CHAN_N; i++) begin
        if (wr_sel[i]) begin
          settled_ff[i] <= 1'b0;
        end else if (settle_ff[i] == `ODL_CNT_W'(1)) begin
          settled_ff[i] <= 1'b1;
        end
      end
    end
  end

  assign o_channel_settled = settled_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] lcnt_ff;
  logic [63:0] chan_flat;
  logic [2:0] wr_idx;

  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      lcnt_ff <= '0;
    end else if (lcnt_ff != `ODL_LINK_FULL) begin
      lcnt_ff <= lcnt_ff + 1'b1;
    end
  end

  assign chan_flat = chan_ff;
  assign wr_idx = 3'(f_addr(word_ff.channel_address_field) - `ODL_ADDR_FIRST);

  property p_shift_step;
    @(posedge i_shift_clk) disable iff (lrst)
      (lcnt_ff != '0) |->
        shift_ff == {$past(shift_ff[`ODL_WORD_W-2:0]), $past(i_serial_in)};
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("shift register did not advance by one bit");

  property p_cascade_out;
    @(posedge i_shift_clk) disable iff (lrst)
      (lcnt_ff == `ODL_LINK_FULL) |-> o_serial_out == $past(i_serial_in, 12);
  endproperty
  a_cascade_out: assert property (p_cascade_out)
    else $error("serial output is not the bit sent twelve edges ago");

  property p_load_start;
    @(posedge i_clk) disable iff (i_srst)
      (st_ff == ST_IDLE && $rose(i_load_strobe)) |-> ##[1:3] st_ff == ST_WRITE;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load strobe did not start a write");

  property p_write_value;
    @(posedge i_clk) disable iff (i_srst)
      (wr_sel != '0) |=>
        o_analog_channel_outputs[$past(wr_idx)] == $past(word_ff.conversion_value_field);
  endproperty
  a_write_value: assert property (p_write_value)
    else $error("selected channel did not take the value");

  property p_addr_order;
    @(posedge i_clk) disable iff (i_srst)
      (st_ff == ST_WRITE && word_ff.channel_address_field == 4'h1) |-> wr_sel == 8'h80;
  endproperty
  a_addr_order: assert property (p_addr_order)
    else $error("address bit order wrong");

  property p_deselect;
    @(posedge i_clk) disable iff (i_srst)
      (st_ff == ST_WRITE && (f_addr(word_ff.channel_address_field) == 4'h0 ||
        f_addr(word_ff.channel_address_field) > `ODL_ADDR_LAST)) |=> $stable(chan_flat);
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselected load changed a channel");

  property p_others_kept;
    @(posedge i_clk) disable iff (i_srst)
      (wr_sel != '0) |=>
        ((chan_flat ^ $past(chan_flat)) & ~f_expand($past(wr_sel))) == '0;
  endproperty
  a_others_kept: assert property (p_others_kept)
    else $error("unselected channel changed");

  property p_hold;
    @(posedge i_clk) disable iff (i_srst)
      (st_ff != ST_WRITE) |=> $stable(chan_flat);
  endproperty
  a_hold: assert property (p_hold)
    else $error("channel changed without a load");

  property p_settle_flag;
    @(posedge i_clk) disable iff (i_srst)
      wr_sel[0] |=> (!o_channel_settled[0]) [*8];
  endproperty
  a_settle_flag: assert property (p_settle_flag)
    else $error("settled flag did not drop after a write");

  property p_sel_onehot;
    @(posedge i_clk) disable iff (i_srst)
      $onehot0(wr_sel);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot)
    else $error("load selected more than one channel");

  property p_sync_delay;
    @(posedge i_clk) disable iff (i_srst)
      $rose(strobe_sync_ff) |-> $past(i_load_strobe, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("load strobe seen before two synchroniser stages");

  property p_word_take;
    @(posedge i_clk) disable iff (i_srst)
      (st_ff == ST_IDLE && strobe_sync_ff) |=> word_ff == $past(shift_ff);
  endproperty
  a_word_take: assert property (p_word_take)
    else $error("captured word differs from the shift register");

  property p_single_write;
    @(posedge i_clk) disable iff (i_srst)
      (wr_sel != '0) |=> (wr_sel == '0) [*2];
  endproperty
  a_single_write: assert property (p_single_write)
    else $error("one strobe wrote a channel twice");

  property p_reset_clear;
    @(posedge i_clk)
      i_srst |=> (chan_flat == {`ODL_CHAN_N{`ODL_VAL_RST}} && o_channel_settled == '1);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear channels and settled flags");

  property p_settle_last;
    @(posedge i_clk) disable iff (i_srst)
      wr_sel[7] |=> (!o_channel_settled[7]) [*8];
  endproperty
  a_settle_last: assert property (p_settle_last)
    else $error("settled flag of the last channel did not drop");

  c_write_ch1: cover property (@(posedge i_clk) disable iff (i_srst) wr_sel[0]);
  c_write_ch8: cover property (@(posedge i_clk) disable iff (i_srst) wr_sel[7]);
  c_deselect: cover property (@(posedge i_clk) disable iff (i_srst)
    st_ff == ST_WRITE && wr_sel == '0);
  c_settled: cover property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_channel_settled[0]));
  c_cascade_full: cover property (@(posedge i_shift_clk) disable iff (lrst)
    lcnt_ff == `ODL_LINK_FULL);
endmodule

// >>> pkg/odl_regs.svh
`ifndef ODL_REGS_SVH
`define ODL_REGS_SVH

`define ODL_WORD_W 12
`define ODL_ADDR_W 4
`define ODL_VAL_W 8
`define ODL_CHAN_N 8
`define ODL_ADDR_LSB 8
`define ODL_VAL_LSB 0
`define ODL_ADDR_FIRST 4'h1
`define ODL_ADDR_LAST 4'h8
`define ODL_VAL_RST 8'h00
`define ODL_SHIFT_RST 12'h000
`define ODL_SETTLE_US 100
`define ODL_CLK_MHZ 100
`define ODL_SETTLE_CYC (`ODL_SETTLE_US * `ODL_CLK_MHZ)
`define ODL_CNT_W 16
`define ODL_LINK_FULL 4'hC

`endif

// >>> pkg/odl_pkg.sv
package odl_pkg;
  typedef logic [7:0] odl_val_t;
  typedef logic [7:0] odl_sel_t;

  typedef struct packed {
    logic [3:0] channel_address_field;
    logic [7:0] conversion_value_field;
  } odl_word_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_HOLD
  } odl_load_e;
endpackage

// >>> dv/odl_host_model.sv
`timescale 1ns/10ps
module odl_host_model (
  // Link to the loader
  output logic o_shift_clk,
  output logic o_serial_in,
  output logic o_load_strobe,
  // Cascade output of the loader
  input wire logic i_serial_out
);
  logic [11:0] so_seen;
  initial begin
    o_shift_clk = 1'b0;
    o_serial_in = 1'b0;
    o_load_strobe = 1'b0;
    so_seen = 12'h000;
  end
  // Shift clock edges, n per call; also used outside frames around reset
  task automatic clocks(input int n);
    repeat (n) begin
      #80 o_shift_clk = 1'b1;
      #5 so_seen = {so_seen[10:0], i_serial_out};
      #75 o_shift_clk = 1'b0;
    end
  endtask
  // One word, first bit first, then an optional load
  task automatic send(input logic [11:0] word, input logic load);
    for (int i = 11; i >= 0; i--) begin
      o_serial_in = word[i];
      clocks(1);
    end
    #60 o_serial_in = ~o_serial_in;
    #200;
    if (load) begin
      o_load_strobe = 1'b1;
      #120 o_load_strobe = 1'b0;
    end
    #100;
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  import odl_pkg::*;
  localparam int unsigned SETTLE = 60;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic shift_clk;
  logic serial_in;
  logic load_strobe;
  logic serial_out;
  odl_val_t [7:0] chan;
  logic [7:0] settled;
  odl_val_t exp_val [8];
  odl_val_t vals [8] = '{8'hFF, 8'h01, 8'h80, 8'h5A, 8'hA5, 8'h7F, 8'hFE, 8'h3C};
  int bad_count = 0;
  int n_tests = 0;
  always #5 i_clk = ~i_clk;
  odl_loader #(.P_SETTLE_CYC(SETTLE)) u_odl_loader (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_shift_clk(shift_clk),
    .i_serial_in(serial_in),
    .i_load_strobe(load_strobe),
    .o_serial_out(serial_out),
    .o_analog_channel_outputs(chan),
    .o_channel_settled(settled)
  );
  odl_host_model u_odl_host_model (
    .o_shift_clk(shift_clk),
    .o_serial_in(serial_in),
    .o_load_strobe(load_strobe),
    .i_serial_out(serial_out)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] mk(input logic [3:0] a, input logic [7:0] v);
    return {a[0], a[1], a[2], a[3], v};
  endfunction
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_chans();
    for (int c = 0; c < 8; c++) begin
      check("channel value", {4'h0, exp_val[c]}, {4'h0, chan[c]});
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] v, input logic load);
    u_odl_host_model.send(mk(a, v), load);
    if (load && a >= 4'h1 && a <= 4'h8) begin
      exp_val[a - 4'h1] = v;
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] w1;
    logic [11:0] w2;
    fork
      begin
        #500000;
        bad_count++;
        tally_and_finish();
      end
    join_none
    for (int c = 0; c < 8; c++) begin
      exp_val[c] = 8'h00;
    end
    // Link reset needs shift edges while reset is high
    fork
      repeat (16) @(negedge i_clk);
      u_odl_host_model.clocks(3);
    join
    @(negedge i_clk);
    i_srst = 1'b0;
    // Link must see reset low for two edges before the first word
    u_odl_host_model.clocks(2);
    @(negedge i_clk);
    check_chans();
    check("settled", 12'h0FF, {4'h0, settled});
    // Every channel in turn, the others must hold
    for (int c = 0; c < 8; c++) begin
      put(4'(c + 1), vals[c], 1'b1);
      check_chans();
      check("settled bit", 12'h000, {11'h000, settled[c]});
      check("cascade bit", {11'h000, 1'(c + 1)}, {11'h000, serial_out});
      repeat (SETTLE + 10) @(negedge i_clk);
      check("settled bit", 12'h001, {11'h000, settled[c]});
    end
    // Deselected addresses
    put(4'h0, 8'hC3, 1'b1);
    check_chans();
    for (int a = 9; a < 16; a++) begin
      put(4'(a), 8'hC3, 1'b1);
      check_chans();
    end
    // Shifting without a load
    put(4'h3, 8'h99, 1'b0);
    check_chans();
    // Cascade stream and the zero code
    w1 = mk(4'h7, 8'hA5);
    w2 = mk(4'h1, 8'h00);
    put(4'h7, 8'hA5, 1'b1);
    put(4'h1, 8'h00, 1'b1);
    check("cascade stream", {w1[10:0], w2[11]}, u_odl_host_model.so_seen);
    check_chans();
    tally_and_finish();
  end
endmodule
